/* hdl/ismc_pkg.sv */
// Constants and types for the interrupt source mode control slice.
// Operation
// [R1] Active-state field value 01 means high level
// [R2] Bit 28 selects DMA trigger per source (code: bit 4 of each source byte, bit 20 for source 34, bit 28 for source 35)
// [R3] Selector 0: field is priority level 1-7
// [R4] Selector 0, field 000: request not forwarded
// [R5] Selector 1: field selects DMA channel 0-7
// [R6] Reset clears all bits; gaps read zero
package ismc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_MODE        = 4'h0;
    localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h1;
    localparam logic [3:0] ADDR_IRQ_ENABLE  = 4'h2;
    localparam logic [3:0] ADDR_IRQ_CLEAR   = 4'h3;
    localparam logic [3:0] ADDR_REQ_STATE   = 4'h4;

    // ------------------------------------------------------------
    // Field layout of one source's byte within the mode register
    // ------------------------------------------------------------
    localparam int SRC34_BYTE       = 16;
    localparam int SRC35_BYTE       = 24;
    localparam int SEL_LSB          = 0;
    localparam int DMA_SEL_BIT      = 4;
    localparam int ACT_LSB          = 5;
    localparam logic [7:0] SRC_MASK = 8'h77;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;

    localparam logic [1:0] ACT_HIGH_LEVEL = 2'h1;
    localparam logic [2:0] SEL_DISABLED   = 3'h0;

    // Status bits: per source, request to CPU and DMA trigger issued.
    localparam int STAT_W = 4;
    localparam logic [STAT_W-1:0] STAT_RESET = 4'h0;

    typedef struct packed {
        logic [1:0] act;
        logic       dma_sel;
        logic [2:0] sel;
    } ismc_src_cfg_t;

    function automatic ismc_src_cfg_t ismc_unpack(input logic [7:0] b);
        ismc_src_cfg_t c;
        c.act     = b[ACT_LSB+1:ACT_LSB];
        c.dma_sel = b[DMA_SEL_BIT];
        c.sel     = b[SEL_LSB+2:SEL_LSB];
        return c;
    endfunction

endpackage

/* hdl/ismc_route_if.sv */
// Interface carrying one source's decoded routing between the modules.
interface ismc_route_if;
    logic       cpu_req;
    logic [2:0] cpu_level;
    logic       dma_req;
    logic [7:0] dma_chan;

    modport src (output cpu_req, output cpu_level, output dma_req, output dma_chan);
    modport dst (input cpu_req, input cpu_level, input dma_req, input dma_chan);
endinterface

/* hdl/ismc_source.sv */
// One source: decodes its mode byte into a CPU or DMA request.
module ismc_source
(
    // Configuration
    input  wire logic [7:0] cfg_byte,
    // Synchronised request level
    input  wire logic       req_level,
    // Routed result
    ismc_route_if.src       route
);
    ismc_pkg::ismc_src_cfg_t cfg;
    logic                    active;

    always_comb
    begin
        cfg    = ismc_pkg::ismc_unpack(cfg_byte);
        // Only the high-level encoding is defined for these sources.
        active = req_level && (cfg.act == ismc_pkg::ACT_HIGH_LEVEL); // [R1]
        route.cpu_req   = active && !cfg.dma_sel
                          && (cfg.sel != ismc_pkg::SEL_DISABLED); // [R2] [R4]
        route.cpu_level = cfg.dma_sel ? 3'h0 : cfg.sel; // [R3]
        route.dma_req   = active && cfg.dma_sel; // [R2]
        route.dma_chan  = 8'h00;
        if (route.dma_req)
        begin
            route.dma_chan[cfg.sel] = 1'b1; // [R5]
        end
    end
endmodule

/* hdl/ismc_top.sv */
// Mode control slice for sources 34 and 35 with register port and interrupt.
//
// Our own choices: the register offsets and the plain strobed port.
module ismc_top
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Request pins, index 0 is source 34, index 1 is source 35
    input  wire logic        compare_group_irq,
    input  wire logic        time_base_tick_irq,
    // Routed outputs
    output logic      [2:0]  src34_cpu_level,
    output logic             src34_cpu_req,
    output logic      [2:0]  src35_cpu_level,
    output logic             src35_cpu_req,
    output logic      [7:0]  dma_trigger,
    // Interrupt
    output logic             irq
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sync1_reg;
    logic [1:0] sync1_next;
    logic [1:0] sync2_reg;
    logic [1:0] sync2_next;

    always_comb
    begin
        sync1_next = {time_base_tick_irq, compare_group_irq};
        sync2_next = sync1_reg;
    end

    always_ff @(posedge clk)
    begin
        sync1_reg <= sync1_next;
        sync2_reg <= sync2_next;
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0]                 mode_reg;
    logic [31:0]                 mode_next;
    logic [ismc_pkg::STAT_W-1:0] stat_reg;
    logic [ismc_pkg::STAT_W-1:0] stat_next;
    logic [ismc_pkg::STAT_W-1:0] en_reg;
    logic [ismc_pkg::STAT_W-1:0] en_next;
    logic [31:0]                 rdata_reg;
    logic [31:0]                 rdata_next;
    logic [ismc_pkg::STAT_W-1:0] events;
    logic [ismc_pkg::STAT_W-1:0] clr;
    logic                        wr_mode;
    logic                        wr_enable;
    logic                        wr_clear;
    logic [7:0]                  src_cfg [2];

    // ------------------------------------------------------------
    // Source decoders
    // ------------------------------------------------------------
    // Index 0 is source 34 and index 1 is source 35, in the same order as the pins.
    ismc_route_if src_route [2] ();

    assign src_cfg[0] = mode_reg[ismc_pkg::SRC34_BYTE +: 8];
    assign src_cfg[1] = mode_reg[ismc_pkg::SRC35_BYTE +: 8];

    generate
        for (genvar s = 0; s < 2; s++)
        begin : g_src
            ismc_source u_src
            (
                .cfg_byte  (src_cfg[s]),
                .req_level (sync2_reg[s]),
                .route     (src_route[s].src)
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    // Every write group qualifies the strobe through this one helper, so a
    // change of the map cannot leave two groups decoding different addresses.
    function automatic logic reg_hit
    (
        input logic       strobe,
        input logic [3:0] addr,
        input logic [3:0] target
    );
        return strobe && (addr == target);
    endfunction

    always_comb
    begin
        wr_mode   = reg_hit(reg_wr, reg_addr, ismc_pkg::ADDR_MODE);
        wr_enable = reg_hit(reg_wr, reg_addr, ismc_pkg::ADDR_IRQ_ENABLE);
        wr_clear  = reg_hit(reg_wr, reg_addr, ismc_pkg::ADDR_IRQ_CLEAR);
    end

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    always_comb
    begin
        mode_next = mode_reg;
        if (wr_mode)
        begin
            // Reserved positions stay zero so they always read back as zero.
            mode_next = '0;
            mode_next[ismc_pkg::SRC34_BYTE +: 8] =
                reg_wdata[ismc_pkg::SRC34_BYTE +: 8] & ismc_pkg::SRC_MASK; // [R6]
            mode_next[ismc_pkg::SRC35_BYTE +: 8] =
                reg_wdata[ismc_pkg::SRC35_BYTE +: 8] & ismc_pkg::SRC_MASK; // [R6]
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mode_reg <= ismc_pkg::MODE_RESET; // [R6]
        end
        else
        begin
            mode_reg <= mode_next;
        end
    end

    // ------------------------------------------------------------
    // Interrupt enable register
    // ------------------------------------------------------------
    always_comb
    begin
        en_next = en_reg;
        if (wr_enable)
        begin
            en_next = reg_wdata[ismc_pkg::STAT_W-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            en_reg <= ismc_pkg::STAT_RESET;
        end
        else
        begin
            en_reg <= en_next;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status register
    // ------------------------------------------------------------
    always_comb
    begin
        clr    = '0;
        events = {src_route[1].dma_req, src_route[1].cpu_req,
                  src_route[0].dma_req, src_route[0].cpu_req};
        if (wr_clear)
        begin
            clr = reg_wdata[ismc_pkg::STAT_W-1:0];
        end
        // A new event in the clearing cycle keeps its bit set.
        stat_next = (stat_reg & ~clr) | events;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stat_reg <= ismc_pkg::STAT_RESET;
        end
        else
        begin
            stat_reg <= stat_next;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Data stand for one cycle after the strobe and are zero otherwise.
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (reg_rd)
        begin
            case (reg_addr)
                ismc_pkg::ADDR_MODE:       rdata_next = mode_reg;
                ismc_pkg::ADDR_IRQ_STATUS: rdata_next = {28'h0, stat_reg};
                ismc_pkg::ADDR_IRQ_ENABLE: rdata_next = {28'h0, en_reg};
                ismc_pkg::ADDR_REQ_STATE:  rdata_next = {30'h0, sync2_reg};
                default:                   rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata       = rdata_reg;
    assign src34_cpu_req   = src_route[0].cpu_req;
    assign src34_cpu_level = src_route[0].cpu_level;
    assign src35_cpu_req   = src_route[1].cpu_req;
    assign src35_cpu_level = src_route[1].cpu_level;
    assign dma_trigger     = src_route[0].dma_chan | src_route[1].dma_chan;
    assign irq             = |(stat_reg & en_reg);
endmodule

/* test/ismc_top_asserts.sv */
// Port checker for the mode control slice.
module ismc_top_asserts
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Register port
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Request pins
    input wire logic        compare_group_irq,
    input wire logic        time_base_tick_irq,
    // Routed outputs and interrupt
    input wire logic [2:0]  src34_cpu_level,
    input wire logic        src34_cpu_req,
    input wire logic [2:0]  src35_cpu_level,
    input wire logic        src35_cpu_req,
    input wire logic [7:0]  dma_trigger,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    a_req_high_level: assert property (src34_cpu_req |-> $past(compare_group_irq, 2))
        else $error("cpu request without high pin");
    a_dma_blocks_cpu: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[28]
        |=> !src35_cpu_req && src35_cpu_level == 3'h0) else $error("dma select left cpu path");
    a_level_taken: assert property (reg_wr && reg_addr == 4'h0 && !reg_wdata[20]
        |=> src34_cpu_level == $past(reg_wdata[18:16])) else $error("level not taken");
    a_zero_level_mute: assert property (src34_cpu_level == 3'h0 |-> !src34_cpu_req)
        else $error("level zero forwarded");
    a_dma_needs_req: assert property (dma_trigger != 8'h0
        |-> $past(compare_group_irq, 2) || $past(time_base_tick_irq, 2))
        else $error("dma trigger without request");
    a_gaps_read_zero: assert property (reg_rd && reg_addr == 4'h0
        |=> (reg_rdata & 32'h8888_ffff) == 32'h0) else $error("gap bits not zero");
    a_reset_clear: assert property (disable iff (1'b0) srst
        |=> reg_rdata == 32'h0 && !irq && dma_trigger == 8'h0) else $error("reset left state");
endmodule

bind ismc_top ismc_top_asserts u_chk (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .compare_group_irq(compare_group_irq), .time_base_tick_irq(time_base_tick_irq),
    .src34_cpu_level(src34_cpu_level), .src34_cpu_req(src34_cpu_req),
    .src35_cpu_level(src35_cpu_level), .src35_cpu_req(src35_cpu_req),
    .dma_trigger(dma_trigger), .irq(irq));

/* test/ismc_req_model.sv */
// Model of the peripherals that raise the two request pins.
module ismc_req_model
(
    // Clock
    input  wire logic       clk,
    // Requested and driven pin levels
    input  wire logic [1:0] want,
    output logic      [1:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // Registered like a real peripheral flag, so pins move one edge late.
    always @(posedge clk)
        pins <= want;
endmodule

/* test/interrupt_source_mode_control_tb.sv */
// Self-checking bench for the mode control slice.
module interrupt_source_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, srst, wr, rd, r34, r35, irq;
    logic        rd_d = 1'b0;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, d;
    logic [31:0] exp_q[$];
    logic [1:0]  want, pins;
    logic [2:0]  l34, l35;
    logic [7:0]  dma;
    int          fails, total_checks;

    ismc_top u_dut (.clk(clk), .srst(srst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .compare_group_irq(pins[0]),
        .time_base_tick_irq(pins[1]), .src34_cpu_level(l34), .src34_cpu_req(r34),
        .src35_cpu_level(l35), .src35_cpu_req(r35), .dma_trigger(dma), .irq(irq));
    ismc_req_model u_req (.clk(clk), .want(want), .pins(pins));

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        exp_q.push_back(e);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe.
    always @(posedge clk)
    begin
        rd_d <= rd;
        if (rd_d)
            cmp("rdata", exp_q.pop_front(), rdata);
    end
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        end_of_test();
    end
    initial
    begin
        srst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 32'h0; want = 2'h0;
        void'($urandom(47399));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rreg(4'h0, 32'h0);
        want <= 2'h3;
        for (int i = 0; i < 8; i++)
        begin
            wreg(4'h0, {8'h0, 8'h20 | 8'(i), 16'h0});
            settle();
            cmp("src34", {28'h0, i != 0, 3'(i)}, {28'h0, r34, l34});
        end
        $display("level test done");
        for (int c = 0; c < 8; c++)
        begin
            wreg(4'h0, {8'h30 | 8'(c), 24'h0});
            settle();
            cmp("dma", 32'h1 << c, {20'h0, r35, l35, dma});
        end
        rreg(4'h4, 32'h3);
        $display("channel test done");
        foreach (d[i])
        begin
            if (i < 3)
            begin
                wreg(4'h0, {1'b0, i == 0 ? 2'h0 : 2'(i + 1), 5'h07, 24'h0});
                settle();
                cmp("act", 32'h0, {31'h0, r35});
            end
        end
        rreg(4'h1, 32'h9);
        d = $urandom;
        wreg(4'h0, d);
        rreg(4'h0, d & 32'h7777_0000);
        $display("mode test done");
        wreg(4'h2, 32'h1);
        rreg(4'h2, 32'h1);
        settle();
        cmp("irq", 32'h1, {31'h0, irq});
        wreg(4'h2, 32'h0);
        want <= 2'h0;
        settle();
        cmp("irq masked", 32'h0, {31'h0, irq});
        wreg(4'h3, 32'hf);
        rreg(4'h1, 32'h0);
        rreg(4'h7, 32'h0);
        settle();
        $display("interrupt test done");
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rreg(4'h0, 32'h0);
        rreg(4'h1, 32'h0);
        settle();
        $display("reset test done");
        end_of_test();
    end
endmodule
